// ===== core/hsd_debug_ctrl.sv
// hsd_debug_ctrl: halting debug control, event ranking and debug status registers
// assumes the debug access port and the processor run on clk; external halt is a raw pin
//
// Behaviour
// - halt 0 step 0 leaves Debug state, runs
// - halt 0 step 1 runs one instruction, halts
// - mask bit blocks tick, service, configurable interrupts
// - halt 1 write keeps Debug state
// - decode only when enabled and halted
// - breakpoint, catch, step synchronous; others asynchronous
// - faulting fetch raises no breakpoint
// - synchronous debug events replace the instruction
// - step event taken on following instruction
// - undefined or faulting access raises no watchpoint
// - four control registers at EDF0 to EDFC
// - EE00 to EEFF reserved, no registers
// - all registers reachable from debug port
// - handler bit 15 reads, writes svc pending
// - svc pending set on request, cleared active
// - event status bits clear on writing one
// - power-on reset clears event status only
// - bit 4 external halt, bit 3 catch
// - debug enable 0 ignores other control bits
// - bit 2 watchpoint, 1 breakpoint, 0 halt
// - control write needs key A05F upper half
// - events halt only while debug enabled
`timescale 1ns/1ps
module hsd_debug_ctrl (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                localReset,
  input  wire logic                externalHaltRequest,
  input  wire hsd_pkg::hsd_core_ev_s coreEv,
  input  wire hsd_pkg::hsd_dap_req_s dapReq,
  output logic                     dapAck,
  output logic                     dapErr,
  output logic [31:0]              dapRdata,
  output logic                     coreHalted,
  output logic                     squashInstr,
  output logic                     maskInts,
  output logic                     svcPending
);

  // ************************************************************
  // state
  // ************************************************************
  hsd_pkg::hsd_state_e state;
  hsd_pkg::hsd_state_e next_state;
  logic        debugEn;
  logic        cHalt;
  logic        cStep;
  logic        cMask;
  logic        stepArmed;
  logic        regRdy;
  logic [31:0] coreRegSel;
  logic [31:0] coreRegData;
  logic [31:0] excMonCtrl;
  logic        extMeta;
  logic        extSync;
  logic [hsd_pkg::EVENT_BITS-1:0] eventStatus;
  logic [1:0]  statusSticky;

  // ************************************************************
  // address decode
  // ************************************************************
  wire hitHcs  = dapReq.addr == hsd_pkg::ADDR_HALT_CONTROL_STATUS;
  wire hitSel  = dapReq.addr == hsd_pkg::ADDR_CORE_REG_SELECTOR;
  wire hitData = dapReq.addr == hsd_pkg::ADDR_CORE_REG_DATA;
  wire hitDemc = dapReq.addr == hsd_pkg::ADDR_EXC_MONITOR_CONTROL;
  wire hitShs  = dapReq.addr == hsd_pkg::ADDR_SYSTEM_HANDLER_STATE;
  wire hitDes  = dapReq.addr == hsd_pkg::ADDR_DEBUG_EVENT_STATUS;
  // reserved window answers as zero and takes no write
  wire hitRsv  = dapReq.addr >= hsd_pkg::ADDR_EXT_RESERVED_LO
              && dapReq.addr <= hsd_pkg::ADDR_EXT_RESERVED_HI;
  wire mapped  = hitHcs | hitSel | hitData | hitDemc | hitShs | hitDes | hitRsv;
  wire wrEn    = dapReq.req & dapReq.write;
  wire rdEn    = dapReq.req & ~dapReq.write;
  wire keyOk   = dapReq.wdata[31:hsd_pkg::KEY_LSB] == hsd_pkg::WRITE_KEY_VALUE;
  wire hcsWr   = wrEn & hitHcs & keyOk;
  wire hcsRd   = rdEn & hitHcs;
  wire selWr   = wrEn & hitSel;
  wire dataWr  = wrEn & hitData;
  wire demcWr  = wrEn & hitDemc;
  wire shsWr   = wrEn & hitShs;
  wire desWr   = wrEn & hitDes;

  wire wrDebugEn = dapReq.wdata[hsd_pkg::BIT_DEBUG_ENABLE];
  wire wrHalt    = dapReq.wdata[hsd_pkg::BIT_HALT_REQ];
  wire wrStep    = dapReq.wdata[hsd_pkg::BIT_STEP];
  wire wrMask    = dapReq.wdata[hsd_pkg::BIT_INT_MASK];

  // ************************************************************
  // external halt pin synchroniser
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extMeta <= 1'b0;
      extSync <= 1'b0;
    end else begin
      extMeta <= externalHaltRequest;
      extSync <= extMeta;
    end
  end

  // ************************************************************
  // debug event ranking
  // ************************************************************
  wire running   = state != hsd_pkg::ST_HALT;
  wire evActive  = debugEn & running;
  // a faulting fetch never reports a breakpoint
  wire syncBkpt  = coreEv.instrValid & coreEv.fetchBkpt & ~coreEv.fetchFault;
  wire syncVc    = coreEv.instrValid & coreEv.vcatchHit;
  // the stepped instruction retired; the next issue is where the step is taken
  wire syncStep  = coreEv.instrValid & stepArmed;
  // no access was made, so no data match can count
  wire wpHit     = coreEv.wpMatch & ~coreEv.undefInstr & ~coreEv.accessMpuFault;
  wire takeSync  = evActive & (syncBkpt | syncVc | syncStep);
  // asynchronous ones wait behind any synchronous event of the cycle
  wire takeAsync = evActive & ~takeSync & (wpHit | cHalt | extSync);
  wire enterHalt = takeSync | takeAsync;

  wire [hsd_pkg::EVENT_BITS-1:0] eventSet = {
    takeAsync & extSync,
    takeSync & syncVc,
    takeAsync & wpHit,
    takeSync & syncBkpt,
    (takeSync & syncStep) | (takeAsync & cHalt)
  };
  wire [hsd_pkg::EVENT_BITS-1:0] eventClr =
    desWr ? dapReq.wdata[hsd_pkg::EVENT_BITS-1:0] : '0;

  // only the power-on reset reaches this register, a local reset leaves it
  hsd_sticky_bits #(.W(hsd_pkg::EVENT_BITS)) u_event_status (
    .clk     (clk),
    .arst_n  (arst_n),
    .setBits (eventSet),
    .clrBits (eventClr),
    .q       (eventStatus)
  );

  // retire and reset stickies clear on a control/status read
  wire [1:0] stickySet = {localReset, coreEv.instrRetire & running};
  wire [1:0] stickyClr = {hcsRd, hcsRd};

  hsd_sticky_bits #(.W(2)) u_status_sticky (
    .clk     (clk),
    .arst_n  (arst_n),
    .setBits (stickySet),
    .clrBits (stickyClr),
    .q       (statusSticky)
  );

  // ************************************************************
  // run / step / halt sequencing
  // ************************************************************
  wire haltedWr = hcsWr & debugEn & ~running;

  always_comb begin
    next_state = state;
    unique case (state)
      hsd_pkg::ST_RUN, hsd_pkg::ST_STEP: begin
        if (enterHalt) begin
          next_state = hsd_pkg::ST_HALT;
        end
      end
      hsd_pkg::ST_HALT: begin
        if (!debugEn) begin
          next_state = hsd_pkg::ST_RUN;
        end else if (haltedWr && !wrHalt && !wrStep) begin
          next_state = hsd_pkg::ST_RUN;
        end else if (haltedWr && !wrHalt && wrStep) begin
          next_state = hsd_pkg::ST_STEP;
        end
      end
    endcase
    if (localReset) begin
      next_state = hsd_pkg::ST_RUN;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= hsd_pkg::ST_RUN;
      coreHalted  <= 1'b0;
      squashInstr <= 1'b0;
      stepArmed   <= 1'b0;
    end else begin
      state       <= next_state;
      coreHalted  <= next_state == hsd_pkg::ST_HALT;
      squashInstr <= takeSync;
      stepArmed   <= (state == hsd_pkg::ST_STEP) && !enterHalt && !localReset
                   && (stepArmed || coreEv.instrRetire);
    end
  end

  // ************************************************************
  // control bits
  // ************************************************************
  // a write with halt held keeps the mask change safe; other changes are dropped, but a write clearing debug enable clears the mask
  wire maskMay = cHalt & wrHalt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      debugEn <= 1'b0;
      cHalt   <= 1'b0;
      cStep   <= 1'b0;
      cMask   <= 1'b0;
    end else if (hcsWr && !wrDebugEn) begin
      debugEn <= 1'b0;
      cHalt   <= 1'b0;
      cStep   <= 1'b0;
      cMask   <= 1'b0;
    end else if (hcsWr) begin
      debugEn <= 1'b1;
      // an event in the same cycle still leaves halt reading 1
      cHalt   <= wrHalt | enterHalt;
      cStep   <= wrStep;
      cMask   <= maskMay ? wrMask : cMask;
    end else if (enterHalt) begin
      cHalt   <= 1'b1;
    end
  end

  // masking only matters while the core runs; nmi is never touched
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      maskInts <= 1'b0;
    end else begin
      maskInts <= debugEn & cMask & (next_state != hsd_pkg::ST_HALT);
    end
  end

  // ************************************************************
  // plain storage and transfer handshake
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coreRegSel  <= hsd_pkg::RESET_WORD;
      coreRegData <= hsd_pkg::RESET_WORD;
      excMonCtrl  <= hsd_pkg::RESET_WORD;
      regRdy      <= hsd_pkg::RESET_REG_READY;
    end else begin
      if (selWr) begin
        coreRegSel <= dapReq.wdata;
      end
      if (dataWr) begin
        coreRegData <= dapReq.wdata;
      end
      if (demcWr) begin
        excMonCtrl <= dapReq.wdata;
      end
      // the selected transfer is treated as done one cycle after the select
      regRdy <= ~selWr;
    end
  end

  // ************************************************************
  // supervisor call pending
  // ************************************************************
  wire svcWrVal = dapReq.wdata[hsd_pkg::BIT_SVC_PENDING];
  // a new request wins over activation and over a written zero
  wire next_svcPending = coreEv.svcRequest
                       | (shsWr ? svcWrVal : (svcPending & ~coreEv.svcActivate));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      svcPending <= 1'b0;
    end else if (localReset) begin
      svcPending <= coreEv.svcRequest;
    end else begin
      svcPending <= next_svcPending;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  wire [3:0]  ctrlRead = debugEn ? {cMask, cStep, cHalt, 1'b1} : 4'h0;
  wire [31:0] hcsRead  = {6'h00, statusSticky[hsd_pkg::STICKY_RESET],
                          statusSticky[hsd_pkg::STICKY_RETIRE], 4'h0, 1'b0, 1'b0,
                          state == hsd_pkg::ST_HALT, regRdy, 12'h000, ctrlRead};
  wire [31:0] shsRead  = {16'h0000, svcPending, 15'h0000};
  wire [31:0] desRead  = {27'h0000000, eventStatus};
  wire [31:0] rdMux    = hitHcs  ? hcsRead
                       : hitData ? coreRegData
                       : hitDemc ? excMonCtrl
                       : hitShs  ? shsRead
                       : hitDes  ? desRead
                       : 32'h0000_0000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dapAck   <= 1'b0;
      dapErr   <= 1'b0;
      dapRdata <= 32'h0000_0000;
    end else begin
      dapAck   <= dapReq.req;
      dapErr   <= dapReq.req & ~mapped;
      dapRdata <= rdEn ? rdMux : 32'h0000_0000;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_resume_run: assert property (
    haltedWr && !wrHalt && !wrStep && !localReset |=> !coreHalted && state == hsd_pkg::ST_RUN
  ) else $error("resume write did not leave halt");

  a_step_leave: assert property (
    haltedWr && !wrHalt && wrStep && !localReset |=> state == hsd_pkg::ST_STEP ##0 !coreHalted
  ) else $error("step write did not start a step");

  a_step_halt: assert property (
    state == hsd_pkg::ST_STEP && stepArmed && coreEv.instrValid && debugEn && !localReset
    |=> coreHalted && eventStatus[hsd_pkg::EV_HALT_STEP] && squashInstr
  ) else $error("step event not taken on next instruction");

  a_mask_out: assert property (
    $rose(cMask) && debugEn |-> ##1 (maskInts || coreHalted)
  ) else $error("mask bit not applied");

  // a write that also clears debug enable resumes on purpose, so it is left out here
  a_halt_stays: assert property (
    haltedWr && wrHalt && wrDebugEn && !localReset |=> coreHalted && cHalt
  ) else $error("halt write left debug state");

  a_run_nodecode: assert property (
    state == hsd_pkg::ST_RUN && hcsWr |=> state != hsd_pkg::ST_STEP
  ) else $error("control decoded while running");

  a_breakpoint_event_flag_fault: assert property (
    $rose(eventStatus[hsd_pkg::EV_BREAKPOINT]) |-> $past(coreEv.fetchBkpt && !coreEv.fetchFault)
  ) else $error("breakpoint from faulting fetch");

  a_wp_gate: assert property (
    $rose(eventStatus[hsd_pkg::EV_WATCHPOINT])
    |-> $past(coreEv.wpMatch && !coreEv.undefInstr && !coreEv.accessMpuFault)
  ) else $error("watchpoint from access that made none");

  a_event_clear: assert property (
    desWr && dapReq.wdata[hsd_pkg::EV_EXTERNAL] && !eventSet[hsd_pkg::EV_EXTERNAL]
    |=> !eventStatus[hsd_pkg::EV_EXTERNAL]
  ) else $error("write one did not clear status");

  a_bad_key: assert property (
    wrEn && hitHcs && !keyOk |=> $stable(debugEn) && $stable(cStep)
  ) else $error("control write without key took effect");

  a_svc_active: assert property (
    coreEv.svcActivate && !coreEv.svcRequest && !shsWr |=> !svcPending
  ) else $error("svc pending kept after activation");

  a_off_ignore: assert property (
    !debugEn && !hcsWr |=> !coreHalted && !maskInts && !squashInstr
  ) else $error("control bits used while debug disabled");

  c_step_done: cover property (
    state == hsd_pkg::ST_STEP ##[1:20] state == hsd_pkg::ST_HALT);
  c_resume: cover property (state == hsd_pkg::ST_HALT ##1 state == hsd_pkg::ST_RUN);
  c_ext_halt: cover property ($rose(eventStatus[hsd_pkg::EV_EXTERNAL]));
  c_breakpoint_event_flag: cover property (takeSync && syncBkpt);

endmodule

// ===== core/hsd_sticky_bits.sv
// hsd_sticky_bits: a vector of sticky flags, set by hardware, cleared by request
// assumes set and clear come from logic on clk; only the asynchronous reset clears all
`timescale 1ns/1ps
module hsd_sticky_bits #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] setBits,
  input  wire logic [W-1:0] clrBits,
  output logic      [W-1:0] q
);

  logic [W-1:0] next_q;

  // set wins over clear so no event is lost in the clearing cycle
  assign next_q = (q & ~clrBits) | setBits;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule

// ===== pkg/hsd_pkg.sv
// halt/step debug control: shared addresses, field positions, reset values and types
// assumes one processor clock; the debug access port is logic on that same clock
package hsd_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [31:0] ADDR_HALT_CONTROL_STATUS  = 32'hE000_EDF0;
  localparam logic [31:0] ADDR_CORE_REG_SELECTOR    = 32'hE000_EDF4;
  localparam logic [31:0] ADDR_CORE_REG_DATA        = 32'hE000_EDF8;
  localparam logic [31:0] ADDR_EXC_MONITOR_CONTROL  = 32'hE000_EDFC;
  localparam logic [31:0] ADDR_SYSTEM_HANDLER_STATE = 32'hE000_EDE0;
  localparam logic [31:0] ADDR_DEBUG_EVENT_STATUS   = 32'hE000_EDE4;
  localparam logic [31:0] ADDR_EXT_RESERVED_LO      = 32'hE000_EE00;
  localparam logic [31:0] ADDR_EXT_RESERVED_HI      = 32'hE000_EEFF;

  // ************************************************************
  // halt_control_status fields
  // ************************************************************
  localparam logic [15:0] WRITE_KEY_VALUE  = 16'hA05F;
  localparam int          KEY_LSB          = 16;
  localparam int          BIT_DEBUG_ENABLE = 0;
  localparam int          BIT_HALT_REQ     = 1;
  localparam int          BIT_STEP         = 2;
  localparam int          BIT_INT_MASK     = 3;
  localparam int          BIT_REG_READY    = 16;
  localparam int          BIT_HALT_STATUS  = 17;
  localparam int          BIT_RETIRE_STICKY = 24;
  localparam int          BIT_RESET_STICKY = 25;

  // ************************************************************
  // other fields and reset values
  // ************************************************************
  localparam int          BIT_SVC_PENDING  = 15;
  localparam int          EVENT_BITS       = 5;
  localparam int          EV_HALT_STEP     = 0;
  localparam int          EV_BREAKPOINT    = 1;
  localparam int          EV_WATCHPOINT    = 2;
  localparam int          EV_VECTOR_CATCH  = 3;
  localparam int          EV_EXTERNAL      = 4;
  localparam int          STICKY_RETIRE    = 0;
  localparam int          STICKY_RESET     = 1;
  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;
  localparam logic        RESET_REG_READY  = 1'b1;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_RUN,
    ST_STEP,
    ST_HALT
  } hsd_state_e;

  // per-cycle report from the processor pipeline
  typedef struct packed {
    logic instrValid;
    logic instrRetire;
    logic fetchBkpt;
    logic fetchFault;
    logic vcatchHit;
    logic wpMatch;
    logic undefInstr;
    logic accessMpuFault;
    logic svcRequest;
    logic svcActivate;
  } hsd_core_ev_s;

  // one access from the debug access port
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hsd_dap_req_s;

endpackage

// ===== testbench/hsd_dbg_model.sv
// hsd_dbg_model: external debugger driving the debug access port of the debug control
// assumes callers start each access from a falling edge; answers come within three cycles
`timescale 1ns/1ps
module hsd_dbg_model (
  input  wire logic             clk,
  output hsd_pkg::hsd_dap_req_s dapReq,
  input  wire logic             dapAck,
  input  wire logic             dapErr,
  input  wire logic [31:0]      dapRdata
);
  // ************************************************************
  // access tasks
  // ************************************************************
  initial dapReq = '0;

  // request held across the taking edge; released fields show inverted values
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int i;
    @(negedge clk);
    dapReq = '{req: 1'b1, write: w, addr: a, wdata: d};
    @(posedge clk);
    @(negedge clk);
    dapReq = '{req: 1'b0, write: ~w, addr: ~a, wdata: ~d};
    q = 'x;
    e = 1'bx;
    for (i = 0; i < 3; i++) begin
      if (dapAck === 1'b1) begin
        q = dapRdata;
        e = dapErr;
        break;
      end
      @(negedge clk);
    end
  endtask

  // control writes always carry the key; callers change mask only with halt held
  // and resume with mask set by two writes, never touching step or mask while running
  task automatic ctl(input logic [15:0] lo);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, hsd_pkg::ADDR_HALT_CONTROL_STATUS, {hsd_pkg::WRITE_KEY_VALUE, lo}, q, e);
  endtask
endmodule

// ===== testbench/tb_halt_step_debug_control.sv
// tb_halt_step_debug_control: self-checking bench for hsd_debug_ctrl
// assumes the debugger model answers through the access port; core events come from here
`timescale 1ns/1ps
module tb_halt_step_debug_control;
  localparam logic [31:0] CTL = hsd_pkg::ADDR_HALT_CONTROL_STATUS;
  localparam logic [31:0] EVS = hsd_pkg::ADDR_DEBUG_EVENT_STATUS;
  localparam logic [31:0] SHS = hsd_pkg::ADDR_SYSTEM_HANDLER_STATE;
  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  localReset = 1'b0;
  logic                  extHalt = 1'b0;
  hsd_pkg::hsd_core_ev_s coreEv = '0;
  hsd_pkg::hsd_dap_req_s dapReq;
  logic                  dapAck, dapErr, coreHalted, squashInstr, maskInts, svcPending;
  logic [31:0]           dapRdata, rdata;
  logic                  rerr;
  int                    n_fail = 0;
  int                    checked = 0;
  int                    cycles = 0;

  // ************************************************************
  // clock, instances, timeout
  // ************************************************************
  initial forever #50 clk = ~clk;
  hsd_debug_ctrl u_dut (.clk(clk), .arst_n(arst_n), .localReset(localReset),
    .externalHaltRequest(extHalt), .coreEv(coreEv), .dapReq(dapReq), .dapAck(dapAck),
    .dapErr(dapErr), .dapRdata(dapRdata), .coreHalted(coreHalted),
    .squashInstr(squashInstr), .maskInts(maskInts), .svcPending(svcPending));
  hsd_dbg_model u_dbg (.clk(clk), .dapReq(dapReq), .dapAck(dapAck), .dapErr(dapErr),
    .dapRdata(dapRdata));
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp, input string msg);
    chk({31'h0, got}, {31'h0, exp}, msg);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp,
                    input logic experr, input string msg);
    u_dbg.xfer(1'b0, a, 32'h0, rdata, rerr);
    chk(rdata & m, exp, msg);
    chkb(rerr, experr, msg);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    u_dbg.xfer(1'b1, a, d, rdata, rerr);
  endtask
  // one cycle of core events; the halt response is visible when this returns
  task automatic ev1(input hsd_pkg::hsd_core_ev_s e);
    @(negedge clk);
    coreEv = e;
    @(negedge clk);
    coreEv = '0;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    rd(CTL, 32'h0003_000F, 32'h0001_0000, 1'b0, "control after reset");
    rd(EVS, 32'hFFFF_FFFF, 32'h0, 1'b0, "events after reset");
    wr(CTL, 32'h0000_0003);
    rd(CTL, 32'h0003_000F, 32'h0001_0000, 1'b0, "keyless write");
    u_dbg.ctl(16'h0003);
    ev1('0);
    chkb(coreHalted, 1'b1, "halt request");
    rd(CTL, 32'h0002_000F, 32'h0002_0003, 1'b0, "halted status");
    rd(EVS, 32'h1F, 32'h01, 1'b0, "halt event bit");
    wr(EVS, 32'h0);
    rd(EVS, 32'h1F, 32'h01, 1'b0, "write zero keeps");
    wr(EVS, 32'h1F);
    rd(EVS, 32'h1F, 32'h00, 1'b0, "write one clears");
    u_dbg.ctl(16'h000B);
    chkb(coreHalted, 1'b1, "mask write with halt");
    u_dbg.ctl(16'h0009);
    ev1('0);
    chkb(coreHalted, 1'b0, "resume");
    chkb(maskInts, 1'b1, "mask while running");
    ev1('{instrValid: 1'b1, vcatchHit: 1'b1, default: 1'b0});
    chkb(coreHalted, 1'b1, "catch halts");
    chkb(squashInstr, 1'b1, "catch squashes");
    rd(EVS, 32'h1F, 32'h08, 1'b0, "catch bit");
    wr(EVS, 32'h1F);
    u_dbg.ctl(16'h0003);
    u_dbg.ctl(16'h0005);
    chkb(coreHalted, 1'b0, "step leaves");
    ev1('{instrValid: 1'b1, instrRetire: 1'b1, default: 1'b0});
    chkb(coreHalted, 1'b0, "stepped instruction runs");
    ev1('{instrValid: 1'b1, default: 1'b0});
    chkb(coreHalted, 1'b1, "halt after step");
    chkb(squashInstr, 1'b1, "following one squashed");
    chkb(maskInts, 1'b0, "mask cleared with halt held");
    rd(EVS, 32'h1F, 32'h01, 1'b0, "step bit");
    u_dbg.ctl(16'h0001);
    ev1('{instrValid: 1'b1, fetchBkpt: 1'b1, fetchFault: 1'b1, default: 1'b0});
    chkb(coreHalted, 1'b0, "faulting fetch");
    ev1('{wpMatch: 1'b1, undefInstr: 1'b1, default: 1'b0});
    ev1('{wpMatch: 1'b1, accessMpuFault: 1'b1, default: 1'b0});
    chkb(coreHalted, 1'b0, "suppressed watchpoints");
    ev1('{instrValid: 1'b1, fetchBkpt: 1'b1, default: 1'b0});
    chkb(coreHalted, 1'b1, "breakpoint");
    u_dbg.ctl(16'h0001);
    ev1('{wpMatch: 1'b1, default: 1'b0});
    chkb(coreHalted, 1'b1, "watchpoint halts");
    chkb(squashInstr, 1'b0, "watchpoint not squashed");
    u_dbg.ctl(16'h0001);
    extHalt = 1'b1;
    repeat (5) @(negedge clk);
    extHalt = 1'b0;
    chkb(coreHalted, 1'b1, "external halt");
    rd(EVS, 32'h1F, 32'h17, 1'b0, "external bit");
    localReset = 1'b1;
    @(negedge clk);
    localReset = 1'b0;
    chkb(coreHalted, 1'b0, "local reset runs");
    rd(EVS, 32'h1F, 32'h17, 1'b0, "local reset keeps events");
    rd(CTL, 32'h0200_0000, 32'h0200_0000, 1'b0, "reset sticky set");
    rd(CTL, 32'h0200_0000, 32'h0, 1'b0, "reset sticky read clears");
    u_dbg.ctl(16'h0000);
    ev1('{instrValid: 1'b1, fetchBkpt: 1'b1, default: 1'b0});
    chkb(coreHalted, 1'b0, "disabled ignores");
    ev1('{svcRequest: 1'b1, default: 1'b0});
    chkb(svcPending, 1'b1, "svc pends");
    rd(SHS, 32'h8000, 32'h8000, 1'b0, "svc read");
    ev1('{svcActivate: 1'b1, default: 1'b0});
    chkb(svcPending, 1'b0, "svc active");
    wr(SHS, 32'h8000);
    ev1('0);
    chkb(svcPending, 1'b1, "svc written");
    ev1('{svcRequest: 1'b1, svcActivate: 1'b1, default: 1'b0});
    chkb(svcPending, 1'b1, "svc request beats activation");
    localReset = 1'b1;
    @(negedge clk);
    localReset = 1'b0;
    chkb(svcPending, 1'b0, "local reset drops svc");
    wr(hsd_pkg::ADDR_CORE_REG_DATA, 32'hA5C3_3C5A);
    rd(hsd_pkg::ADDR_CORE_REG_DATA, '1, 32'hA5C3_3C5A, 1'b0, "data store");
    wr(hsd_pkg::ADDR_EXC_MONITOR_CONTROL, 32'h1234_5678);
    rd(hsd_pkg::ADDR_EXC_MONITOR_CONTROL, '1, 32'h1234_5678, 1'b0, "monitor");
    rd(hsd_pkg::ADDR_CORE_REG_SELECTOR, '1, 32'h0, 1'b0, "selector write only");
    wr(32'hE000_EEFC, 32'hFFFF_FFFF);
    rd(32'hE000_EEFC, '1, 32'h0, 1'b0, "extension window");
    rd(32'hE000_ED00, '1, 32'h0, 1'b1, "unmapped");
    // a second power-on reset in mid-run must clear what the local reset kept
    arst_n = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
    rd(EVS, 32'hFFFF_FFFF, 32'h0, 1'b0, "power-on clears events");
    rd(CTL, 32'h0003_000F, 32'h0001_0000, 1'b0, "power-on clears control");
    results();
  end
endmodule
